/* File: ucb_pkg.sv */
// Constants, field layouts and carrier types of the serial transceiver block.
// Assumes one system clock acting as the oscillator and a byte-wide register port.
package ucb_pkg;

   // Register byte offsets on the register port
   localparam logic [7:0] RCV_CTRL_ADDR = 8'h18;
   localparam logic [7:0] XMT_DATA_ADDR = 8'h19;
   localparam logic [7:0] RCV_DATA_ADDR = 8'h1a;
   localparam logic [7:0] XMT_CTRL_ADDR = 8'h98;
   localparam logic [7:0] BAUD_DIV_ADDR = 8'h99;

   // Reset values
   localparam logic [7:0] XMT_CTRL_RESET = 8'h02;
   localparam logic [7:0] RCV_CTRL_RESET = 8'h00;
   localparam logic [7:0] BAUD_DIV_RESET = 8'h00;

   // Baud divide factors per mode
   localparam int ASYNC_LOW_DIV = 64;
   localparam int ASYNC_HIGH_DIV = 16;
   localparam int SYNC_DIV = 4;

   // Oversampling and sample points inside one asynchronous bit
   localparam logic [3:0] LAST_PHASE = 4'(ASYNC_HIGH_DIV - 1);
   localparam logic [1:0] LOW_PRESCALE_LAST = 2'(ASYNC_LOW_DIV / ASYNC_HIGH_DIV - 1);
   localparam logic [3:0] SAMPLE_PHASE_A = 4'h7;
   localparam logic [3:0] SAMPLE_PHASE_B = 4'h8;
   localparam logic [3:0] SAMPLE_PHASE_C = 4'h9;

   // Synchronous clock edges within one bit of SYNC_DIV baud ticks
   localparam logic [1:0] SCLK_RISE_AT = 2'(SYNC_DIV / 4);
   localparam logic [1:0] SCLK_FALL_AT = 2'(SYNC_DIV - 1);

   // Character lengths in bits
   localparam logic [3:0] DATA_BITS_8 = 4'h8;
   localparam logic [3:0] DATA_BITS_9 = 4'h9;
   localparam logic [3:0] FRAME_BITS_8 = 4'ha;
   localparam logic [3:0] FRAME_BITS_9 = 4'hb;

   typedef struct packed {
      logic clock_source_select;
      logic tx_nine_bit_select;
      logic transmit_enable;
      logic sync_mode;
      logic unused;
      logic high_speed_select;
      logic shift_empty_flag;
      logic tx_ninth_data;
   } ucb_tx_ctrl_type;

   typedef struct packed {
      logic port_enable;
      logic rx_nine_bit_select;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic address_detect_enable;
      logic framing_error_flag;
      logic overrun_error_flag;
      logic rx_ninth_data;
   } ucb_rx_ctrl_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ucb_bus_req_type;

   typedef struct packed {
      logic txck_out;
      logic txck_oe;
      logic rxdt_out;
      logic rxdt_oe;
   } ucb_pin_out_type;

endpackage

/* File: ucb_term_model.sv */
// Terminal model: sends async frames on the data line, decodes the transmit line.
// Assumes the bench resolves a released transmit line to idle high.
`timescale 1ns/1ps
module ucb_term_model (
   // Clock
   input wire logic mclk,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;

   // Low start, LSB first, chosen stop level, then idle high
   task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bc);
      for (int i = -1; i <= nb; i++) begin
         @(posedge mclk);
         line_out <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
         repeat (bc - 1) @(posedge mclk);
      end
      @(posedge mclk);
      line_out <= 1'b1;
      repeat (2 * bc) @(posedge mclk);
   endtask

   // Samples mid-bit; gives up on a silent line
   task automatic recv(input int nb, input int bc, output logic [8:0] d, output logic stop);
      int n;
      d = '0;
      n = 0;
      while (line_in !== 1'b0 && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      repeat (bc / 2) @(posedge mclk);
      for (int i = 0; i < nb; i++) begin
         repeat (bc) @(posedge mclk);
         d[i] = line_in;
      end
      repeat (bc) @(posedge mclk);
      stop = line_in;
   endtask
endmodule

/* File: ucb_usart.sv */
// Serial transceiver: control/status registers, baud generator, shifters.
// Assumes pins and register strobes synchronous to mclk; mclk is the oscillator.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module ucb_usart (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire ucb_pkg::ucb_bus_req_type bus_req,
   output logic [7:0] reg_rdata,
   // Serial pins
   input wire logic [1:0] pin_direction_bits,
   input wire logic txck_in,
   input wire logic rxdt_in,
   output ucb_pkg::ucb_pin_out_type pins_out
);
   import ucb_pkg::*;

   typedef struct packed {
      ucb_tx_ctrl_type txc;
      ucb_rx_ctrl_type rxc;
      logic [7:0] divisor;
      logic [7:0] baud_cnt;
      logic [1:0] pre_cnt;
      logic [7:0] tx_buf;
      logic tx_buf_full;
      logic [10:0] tx_shift;
      logic [3:0] tx_left;
      logic [3:0] tx_phase;
      logic tx_busy;
      logic [8:0] rx_shift;
      logic [3:0] rx_bits;
      logic [3:0] rx_phase;
      logic rx_busy;
      logic [1:0] votes;
      logic [7:0] rx_data;
      logic rx_full;
      logic [1:0] sclk_cnt;
      logic sclk;
      logic ck_prev;
      logic [7:0] rdata;
      ucb_pin_out_type pins;
   } ucb_state_type;

   localparam ucb_state_type STATE_RESET = '{
      txc: XMT_CTRL_RESET,
      rxc: RCV_CTRL_RESET,
      divisor: BAUD_DIV_RESET,
      ck_prev: 1'b1,
      default: '0
   };

   ucb_state_type state_reg;
   ucb_state_type state_next;
   logic port_ok;
   logic sync_rx_on;
   logic sync_tx_on;
   logic baud_tick;
   logic sub_tick;
   logic rise_ev;
   logic fall_ev;
   logic tx_start;
   logic rx_done;
   logic rx_stop_bad;
   logic rx_accept;
   logic rx_bit;
   logic [3:0] rx_nbits;
   logic [8:0] rx_word;

   function automatic logic ucb_majority(input logic [1:0] v, input logic c);
      ucb_majority = (v[0] & v[1]) | (v[0] & c) | (v[1] & c);
   endfunction

   // Eight-bit characters end up one place high in the right-shifting register
   function automatic logic [8:0] ucb_align(input logic [8:0] sh, input logic nine);
      ucb_align = nine ? sh : {1'b0, sh[8:1]};
   endfunction

   always_comb begin
      state_next = state_reg;
      tx_start = 1'b0;
      rx_done = 1'b0;
      rx_stop_bad = 1'b0;
      rx_accept = 1'b0;
      rx_bit = 1'b0;
      rx_word = '0;
      baud_tick = 1'b0;
      sub_tick = 1'b0;
      rise_ev = 1'b0;
      fall_ev = 1'b0;
      port_ok = state_reg.rxc.port_enable & (pin_direction_bits == 2'b11);
      sync_rx_on = state_reg.txc.sync_mode & (state_reg.rxc.continuous_receive_enable
         | (state_reg.rxc.single_receive_enable & state_reg.txc.clock_source_select));
      sync_tx_on = state_reg.txc.sync_mode & state_reg.txc.transmit_enable
         & ~state_reg.rxc.continuous_receive_enable & ~state_reg.rxc.single_receive_enable;
      rx_nbits = state_reg.rxc.rx_nine_bit_select ? DATA_BITS_9 : DATA_BITS_8;

      // Free-running baud timer, one tick every divisor+1 clocks
      if (state_reg.baud_cnt == state_reg.divisor) begin
         state_next.baud_cnt = 8'h00;
         baud_tick = 1'b1;
      end else begin
         state_next.baud_cnt = state_reg.baud_cnt + 8'h01;
      end
      if (baud_tick) begin
         state_next.pre_cnt = state_reg.pre_cnt + 2'h1;
         // 16 sub-ticks per bit: x16 range direct, x64 range divided by four
         sub_tick = state_reg.txc.high_speed_select | (state_reg.pre_cnt == LOW_PRESCALE_LAST);
      end

      // Synchronous clock: generated as master, followed as slave
      state_next.ck_prev = txck_in;
      if (state_reg.txc.sync_mode && port_ok) begin
         if (state_reg.txc.clock_source_select) begin
            if (sync_rx_on || state_reg.tx_busy) begin
               if (baud_tick) begin
                  state_next.sclk_cnt = state_reg.sclk_cnt + 2'h1;
                  if (state_reg.sclk_cnt == SCLK_RISE_AT) begin
                     state_next.sclk = 1'b1;
                     rise_ev = 1'b1;
                  end
                  if (state_reg.sclk_cnt == SCLK_FALL_AT) begin
                     state_next.sclk = 1'b0;
                     fall_ev = 1'b1;
                  end
               end
            end else begin
               state_next.sclk_cnt = 2'h0;
               state_next.sclk = 1'b0;
            end
         end else begin
            rise_ev = ~state_reg.ck_prev & txck_in;
            fall_ev = state_reg.ck_prev & ~txck_in;
         end
      end

      // Register writes; hardware events below take precedence
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            XMT_CTRL_ADDR: begin
               state_next.txc = bus_req.wdata;
               state_next.txc.unused = 1'b0;
               state_next.txc.shift_empty_flag = state_reg.txc.shift_empty_flag;
            end
            RCV_CTRL_ADDR: begin
               state_next.rxc.port_enable = bus_req.wdata[7];
               state_next.rxc.rx_nine_bit_select = bus_req.wdata[6];
               state_next.rxc.single_receive_enable = bus_req.wdata[5];
               state_next.rxc.continuous_receive_enable = bus_req.wdata[4];
               state_next.rxc.address_detect_enable = bus_req.wdata[3];
               if (!bus_req.wdata[4]) begin
                  state_next.rxc.overrun_error_flag = 1'b0;
               end
            end
            BAUD_DIV_ADDR: begin
               state_next.divisor = bus_req.wdata;
               state_next.baud_cnt = 8'h00;
               state_next.pre_cnt = 2'h0;
            end
            XMT_DATA_ADDR: begin
               // A write into a full buffer replaces the waiting byte
               state_next.tx_buf = bus_req.wdata;
               state_next.tx_buf_full = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // Transmitter
      if (!port_ok || !state_reg.txc.transmit_enable) begin
         state_next.tx_busy = 1'b0;
      end else if (!state_reg.tx_busy) begin
         if (state_reg.tx_buf_full
             && (state_reg.txc.sync_mode ? sync_tx_on : 1'b1)) begin
            tx_start = 1'b1;
            state_next.tx_buf_full = bus_req.wr && bus_req.addr == XMT_DATA_ADDR;
            state_next.tx_busy = 1'b1;
            state_next.tx_phase = 4'h0;
            if (state_reg.txc.sync_mode) begin
               state_next.tx_shift = {2'b11, state_reg.txc.tx_ninth_data, state_reg.tx_buf};
               state_next.tx_left = state_reg.txc.tx_nine_bit_select ? DATA_BITS_9
                  : DATA_BITS_8;
            end else if (state_reg.txc.tx_nine_bit_select) begin
               state_next.tx_shift = {1'b1, state_reg.txc.tx_ninth_data, state_reg.tx_buf,
                  1'b0};
               state_next.tx_left = FRAME_BITS_9;
            end else begin
               state_next.tx_shift = {2'b11, state_reg.tx_buf, 1'b0};
               state_next.tx_left = FRAME_BITS_8;
            end
         end
      end else if (state_reg.txc.sync_mode ? fall_ev
                   : (sub_tick && state_reg.tx_phase == LAST_PHASE)) begin
         state_next.tx_shift = {1'b1, state_reg.tx_shift[10:1]};
         state_next.tx_left = state_reg.tx_left - 4'h1;
         state_next.tx_phase = 4'h0;
         if (state_reg.tx_left == 4'h1) begin
            state_next.tx_busy = 1'b0;
         end
      end else if (sub_tick && !state_reg.txc.sync_mode) begin
         state_next.tx_phase = state_reg.tx_phase + 4'h1;
      end
      state_next.txc.shift_empty_flag = ~state_next.tx_busy;

      // Receiver
      if (!port_ok || !(state_reg.txc.sync_mode ? sync_rx_on
                        : state_reg.rxc.continuous_receive_enable)) begin
         state_next.rx_busy = 1'b0;
         state_next.rx_bits = 4'h0;
      end else if (state_reg.txc.sync_mode) begin
         if (rise_ev) begin
            state_next.rx_shift = {rxdt_in, state_reg.rx_shift[8:1]};
            state_next.rx_bits = state_reg.rx_bits + 4'h1;
            if (state_reg.rx_bits == rx_nbits - 4'h1) begin
               rx_done = 1'b1;
               state_next.rx_bits = 4'h0;
               rx_word = ucb_align(state_next.rx_shift, state_reg.rxc.rx_nine_bit_select);
            end
         end
      end else if (!state_reg.rx_busy) begin
         if (!rxdt_in) begin
            state_next.rx_busy = 1'b1;
            state_next.rx_phase = 4'h0;
            state_next.rx_bits = 4'h0;
         end
      end else if (sub_tick) begin
         state_next.rx_phase = state_reg.rx_phase + 4'h1;
         if (state_reg.rx_phase == SAMPLE_PHASE_A) begin
            state_next.votes[0] = rxdt_in;
         end
         if (state_reg.rx_phase == SAMPLE_PHASE_B) begin
            state_next.votes[1] = rxdt_in;
         end
         if (state_reg.rx_phase == SAMPLE_PHASE_C) begin
            rx_bit = ucb_majority(state_reg.votes, rxdt_in);
            if (state_reg.rx_bits == 4'h0) begin
               // A start bit that votes high was a glitch
               state_next.rx_busy = ~rx_bit;
               state_next.rx_bits = 4'h1;
            end else if (state_reg.rx_bits <= rx_nbits) begin
               state_next.rx_shift = {rx_bit, state_reg.rx_shift[8:1]};
               state_next.rx_bits = state_reg.rx_bits + 4'h1;
            end else begin
               rx_done = 1'b1;
               rx_stop_bad = ~rx_bit;
               rx_word = ucb_align(state_reg.rx_shift, state_reg.rxc.rx_nine_bit_select);
               state_next.rx_busy = 1'b0;
            end
         end
      end

      // Reading the data register frees it; a word done in the same cycle still finds it full and sets overrun
      if (bus_req.rd && bus_req.addr == RCV_DATA_ADDR) begin
         state_next.rx_full = 1'b0;
      end
      if (rx_done) begin
         rx_accept = ~(~state_reg.txc.sync_mode & state_reg.rxc.rx_nine_bit_select
            & state_reg.rxc.address_detect_enable & ~rx_word[8]);
         if (rx_accept) begin
            if (state_reg.rx_full || state_reg.rxc.overrun_error_flag) begin
               state_next.rxc.overrun_error_flag = 1'b1;
            end else begin
               state_next.rx_data = rx_word[7:0];
               state_next.rxc.rx_ninth_data = rx_word[8];
               state_next.rxc.framing_error_flag = rx_stop_bad;
               state_next.rx_full = 1'b1;
            end
         end
         if (state_reg.txc.sync_mode && state_reg.txc.clock_source_select) begin
            state_next.rxc.single_receive_enable = 1'b0;
         end
      end

      // Read data stand only in the cycle after the strobe
      state_next.rdata = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            XMT_CTRL_ADDR: state_next.rdata = state_reg.txc;
            RCV_CTRL_ADDR: state_next.rdata = state_reg.rxc;
            BAUD_DIV_ADDR: state_next.rdata = state_reg.divisor;
            RCV_DATA_ADDR: state_next.rdata = state_reg.rx_data;
            default: state_next.rdata = 8'h00;
         endcase
      end

      // Pin drive, one clock behind the shifters
      state_next.pins = '0;
      if (port_ok) begin
         if (!state_reg.txc.sync_mode) begin
            state_next.pins.txck_oe = 1'b1;
            state_next.pins.txck_out = state_reg.tx_busy ? state_reg.tx_shift[0] : 1'b1;
         end else begin
            state_next.pins.txck_oe = state_reg.txc.clock_source_select;
            state_next.pins.txck_out = state_reg.sclk;
            state_next.pins.rxdt_oe = state_reg.tx_busy;
            state_next.pins.rxdt_out = state_reg.tx_busy ? state_reg.tx_shift[0] : 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.rdata;
   assign pins_out = state_reg.pins;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_port_off;
      !port_ok |=> !pins_out.txck_oe && !pins_out.rxdt_oe;
   endproperty
   a_port_off: assert property (p_port_off) else $error("pins driven while port off");

   property p_sync_prio;
      state_reg.txc.sync_mode && (state_reg.rxc.continuous_receive_enable
         || state_reg.rxc.single_receive_enable) |-> !tx_start;
   endproperty
   a_sync_prio: assert property (p_sync_prio) else $error("transmit started over receive");

   property p_bit3_zero;
      bus_req.rd && bus_req.addr == XMT_CTRL_ADDR |=> reg_rdata[3] == 1'b0;
   endproperty
   a_bit3_zero: assert property (p_bit3_zero) else $error("control bit three read nonzero");

   property p_empty_flag;
      tx_start |=> !state_reg.txc.shift_empty_flag ##0 state_reg.tx_busy;
   endproperty
   a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong after load");

   property p_single_clear;
      rx_done && state_reg.txc.sync_mode && state_reg.txc.clock_source_select
         |=> !state_reg.rxc.single_receive_enable;
   endproperty
   a_single_clear: assert property (p_single_clear) else $error("single receive not cleared");

   property p_addr_drop;
      rx_done && !rx_accept |=> $stable(state_reg.rx_data) && $stable(state_reg.rxc.overrun_error_flag);
   endproperty
   a_addr_drop: assert property (p_addr_drop) else $error("address byte filter failed");

   property p_framing;
      rx_done && rx_accept && !state_reg.rx_full && !state_reg.rxc.overrun_error_flag
         |=> state_reg.rxc.framing_error_flag == $past(rx_stop_bad) && state_reg.rx_full;
   endproperty
   a_framing: assert property (p_framing) else $error("framing flag not loaded");

   property p_overrun_hold;
      state_reg.rxc.overrun_error_flag && !(bus_req.wr && bus_req.addr == RCV_CTRL_ADDR
         && !bus_req.wdata[4]) |=> state_reg.rxc.overrun_error_flag;
   endproperty
   a_overrun_hold: assert property (p_overrun_hold) else $error("overrun flag lost");

   property p_baud_period;
      state_reg.baud_cnt == state_reg.divisor && !(bus_req.wr && bus_req.addr == BAUD_DIV_ADDR)
         ##1 !(bus_req.wr && bus_req.addr == BAUD_DIV_ADDR) |=> state_reg.baud_cnt == 8'h01
         || state_reg.divisor == 8'h00;
   endproperty
   a_baud_period: assert property (p_baud_period) else $error("baud timer did not wrap");

   property p_baud_restart;
      bus_req.wr && bus_req.addr == BAUD_DIV_ADDR |=> state_reg.baud_cnt == 8'h00;
   endproperty
   a_baud_restart: assert property (p_baud_restart) else $error("baud timer not restarted");

   c_async_tx: cover property (tx_start && !state_reg.txc.sync_mode);
   c_sync_rx: cover property (rx_done && state_reg.txc.sync_mode);
   c_overrun: cover property (!state_reg.rxc.overrun_error_flag ##1 state_reg.rxc.overrun_error_flag);
   c_framing_error_flag: cover property (rx_done && rx_stop_bad);

endmodule

/* File: usart_control_and_baud_config_test.sv */
// Self-checking bench of the serial transceiver with an async terminal model.
// Assumes a pull-up on the transmit line while the block does not drive it.
`timescale 1ns/1ps
module usart_control_and_baud_config_test;
   import ucb_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   ucb_bus_req_type bus_req = '0;
   logic [7:0] reg_rdata;
   logic [1:0] pin_direction_bits = 2'b00;
   logic rxdt_line;
   logic tx_line;
   ucb_pin_out_type pins_out;
   int miscompares = 0;
   int num_checks = 0;
   logic [8:0] d;
   logic st;

   always #20 mclk = ~mclk;
   assign tx_line = pins_out.txck_oe ? pins_out.txck_out : 1'b1;

   ucb_usart dut_u (.mclk(mclk), .resetn(resetn), .bus_req(bus_req), .reg_rdata(reg_rdata),
      .pin_direction_bits(pin_direction_bits), .txck_in(tx_line), .rxdt_in(rxdt_line),
      .pins_out(pins_out));
   ucb_term_model term_u (.mclk(mclk), .line_in(tx_line), .line_out(rxdt_line));

   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1;
      check(what, {1'b0, reg_rdata}, {1'b0, e});
   endtask

   task automatic t_reset();
      rdchk(XMT_CTRL_ADDR, 8'h02, "tx ctrl reset");
      rdchk(RCV_CTRL_ADDR, 8'h00, "rx ctrl reset");
      rdchk(BAUD_DIV_ADDR, 8'h00, "divisor reset");
      rdchk(8'h55, 8'h00, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_fields();
      wr(XMT_CTRL_ADDR, 8'hff);
      rdchk(XMT_CTRL_ADDR, 8'hf7, "tx ctrl all ones");
      wr(RCV_CTRL_ADDR, 8'hff);
      rdchk(RCV_CTRL_ADDR, 8'hf8, "rx ctrl all ones");
      wr(XMT_CTRL_ADDR, 8'h00);
      wr(RCV_CTRL_ADDR, 8'h00);
      rdchk(XMT_CTRL_ADDR, 8'h02, "tx ctrl cleared");
      $display("test fields done");
   endtask

   // Queued byte must wait for both direction bits
   task automatic t_tx_fast();
      wr(RCV_CTRL_ADDR, 8'h80);
      wr(BAUD_DIV_ADDR, 8'h00);
      wr(XMT_CTRL_ADDR, 8'h24);
      wr(XMT_DATA_ADDR, 8'ha5);
      repeat (40) @(posedge mclk);
      check("tx drive while disabled", {8'h00, pins_out.txck_oe}, 9'h000);
      pin_direction_bits <= 2'b11;
      fork
         term_u.recv(8, 16, d, st);
         begin
            repeat (40) @(posedge mclk);
            rdchk(XMT_CTRL_ADDR, 8'h24, "shifter busy");
         end
      join
      check("tx byte high speed", d, 9'h0a5);
      check("tx stop", {8'h00, st}, 9'h001);
      repeat (20) @(posedge mclk);
      rdchk(XMT_CTRL_ADDR, 8'h26, "shifter empty");
      $display("test tx fast done");
   endtask

   // Low speed, divisor 1: 128 clocks per bit
   task automatic t_tx_nine();
      wr(BAUD_DIV_ADDR, 8'h01);
      wr(XMT_CTRL_ADDR, 8'h61);
      wr(XMT_DATA_ADDR, 8'h3c);
      term_u.recv(9, 128, d, st);
      check("tx nine bit low speed", d, 9'h13c);
      check("tx nine stop", {8'h00, st}, 9'h001);
      $display("test tx nine done");
   endtask

   // Synchronous master: data valid at each rising clock, LSB first; idle data line reads ones
   task automatic t_sync();
      logic [7:0] got;
      got = '0;
      wr(XMT_CTRL_ADDR, 8'h00);
      wr(BAUD_DIV_ADDR, 8'h00);
      wr(XMT_CTRL_ADDR, 8'hb0);
      wr(XMT_DATA_ADDR, 8'h96);
      for (int i = 0; i < 8; i++) begin
         @(posedge pins_out.txck_out);
         check("sync data drive", {8'h00, pins_out.rxdt_oe}, 9'h001);
         got[i] = pins_out.rxdt_out;
      end
      check("sync byte", {1'b0, got}, 9'h096);
      repeat (8) @(posedge mclk);
      rdchk(XMT_CTRL_ADDR, 8'hb2, "sync shifter empty");
      wr(XMT_CTRL_ADDR, 8'h90);
      wr(RCV_CTRL_ADDR, 8'ha0);
      repeat (60) @(posedge mclk);
      rdchk(RCV_CTRL_ADDR, 8'h80, "single receive cleared");
      rdchk(RCV_DATA_ADDR, 8'hff, "sync byte received");
      $display("test sync done");
   endtask

   task automatic t_rx();
      wr(XMT_CTRL_ADDR, 8'h04);
      wr(BAUD_DIV_ADDR, 8'h00);
      wr(RCV_CTRL_ADDR, 8'h90);
      term_u.send(9'h05a, 8, 1'b1, 16);
      rdchk(RCV_DATA_ADDR, 8'h5a, "rx byte");
      rdchk(RCV_CTRL_ADDR, 8'h90, "rx no framing error");
      term_u.send(9'h081, 8, 1'b0, 16);
      rdchk(RCV_CTRL_ADDR, 8'h94, "rx framing error");
      rdchk(RCV_DATA_ADDR, 8'h81, "rx byte low stop");
      $display("test rx done");
   endtask

   task automatic t_overrun();
      term_u.send(9'h011, 8, 1'b1, 16);
      term_u.send(9'h022, 8, 1'b1, 16);
      rdchk(RCV_CTRL_ADDR, 8'h92, "overrun set");
      rdchk(RCV_DATA_ADDR, 8'h11, "first byte kept");
      wr(RCV_CTRL_ADDR, 8'h80);
      rdchk(RCV_CTRL_ADDR, 8'h80, "overrun cleared");
      $display("test overrun done");
   endtask

   // Ninth bit zero dropped, so no overrun on the next one
   task automatic t_addr();
      wr(RCV_CTRL_ADDR, 8'hd8);
      term_u.send(9'h033, 9, 1'b1, 16);
      term_u.send(9'h1c4, 9, 1'b1, 16);
      rdchk(RCV_CTRL_ADDR, 8'hd9, "addr detect status");
      rdchk(RCV_DATA_ADDR, 8'hc4, "addr detect byte");
      $display("test address detect done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      $display("unexpected watchdog: expected done seen hang");
      summarize();
   end

   initial begin
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_fields();
      t_tx_fast();
      t_tx_nine();
      t_sync();
      t_rx();
      t_overrun();
      t_addr();
      summarize();
   end
endmodule
